// [shared/scm_params.svh]
// Offsets, field positions, reset values and limits of the scan controller.
`ifndef SCM_PARAMS_SVH
`define SCM_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the bus
// ----------------------------------------------------------------------
`define SCM_OFF_CMD      8'h00
`define SCM_OFF_CFG      8'h04
`define SCM_OFF_COUNT    8'h08
`define SCM_OFF_CNT_MIN  8'h0c
`define SCM_OFF_CNT_MAX  8'h10
`define SCM_OFF_MONCARD  8'h14
`define SCM_OFF_STATUS   8'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SCM_CMD_START    0
`define SCM_CMD_ABORT    1
`define SCM_CMD_RST      2
`define SCM_CNT_KW_LSB   16
`define SCM_MON_AUTO     7
`define SCM_MON_EFF_LSB  8
`define SCM_ST_RUN       0
`define SCM_ST_PANEL     1
`define SCM_ST_ERR       2
`define SCM_ST_PASS_LSB  16

// ----------------------------------------------------------------------
// Limits and reset values
// ----------------------------------------------------------------------
`define SCM_COUNT_MIN    15'h0001
`define SCM_COUNT_MAX    15'h7fff
`define SCM_COUNT_RST    15'h0001
`define SCM_CARD_MIN     7'h01
`define SCM_CARD_MAX     7'h63
`define SCM_CARD_RST     7'h01
`define SCM_CFG_RST      7'h00

`endif

// [shared/scm_pkg.sv]
// Types shared by the scan controller modules.
package scm_pkg;

  // Trigger source selection held in the configuration register.
  typedef enum logic [2:0] {
    SCM_SRC_BUS  = 3'h0,
    SCM_SRC_DBUS = 3'h1,
    SCM_SRC_EXT  = 3'h2,
    SCM_SRC_HOLD = 3'h3,
    SCM_SRC_IMM  = 3'h4
  } scm_src_t;

  // Scan sequencing states, Gray coded along idle, run, stop.
  typedef enum logic [1:0] {
    SCM_IDLE = 2'b00,
    SCM_RUN  = 2'b01,
    SCM_STOP = 2'b11
  } scm_state_t;

  // Keyword field of a repeat-count write.
  typedef enum logic [1:0] {
    SCM_KW_NUM = 2'h0,
    SCM_KW_MIN = 2'h1,
    SCM_KW_MAX = 2'h2
  } scm_kw_t;

  // Scan and monitor configuration, bit 0 upward as listed last to first.
  typedef struct packed {
    logic mon_en;
    logic switchbox;
    logic dl_list;
    scm_src_t src;
    logic loop_forever_enable;
  } scm_cfg_t;

endpackage

// [verilog/scm_sync.sv]
// Two-flop synchroniser with rising-edge pulse for asynchronous pins.
`timescale 1ns/1ps
module scm_sync #(
  parameter int W = 4
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Raw pins from outside the clock domain.
  input wire logic [W-1:0] pin,
  // Synchronised rising edges, one cycle each.
  output logic [W-1:0] rise
);

  // ----------------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------------
  logic [W-1:0] meta_r; // First stage, read by the second stage only.
  logic [W-1:0] sync_r; // Second stage, safe to use.
  logic [W-1:0] prev_r; // Delayed copy for edge detection.
  logic [W-1:0] rise_nxt;

  // Edge detection looks only at the settled stages.
  always_comb begin
    rise_nxt = sync_r & ~prev_r;
  end

  // All stages freeze while the clock enable is low.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else if (ce) begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign rise = rise_nxt & {W{ce}};

endmodule

// [verilog/scm_pass_ctr.sv]
// Completed-pass counter for counted scanning.
`timescale 1ns/1ps
module scm_pass_ctr (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Control.
  input wire logic clr,
  input wire logic inc,
  input wire logic counted,
  input wire logic [14:0] limit,
  // Results.
  output logic done,
  output logic [14:0] passes
);

  logic [14:0] pass_r;   // Passes finished since the last start.
  logic [14:0] pass_nxt;
  logic [14:0] pass_inc;

  // A pass ending on the limit stops the scan; loop mode never ends here.
  always_comb begin
    pass_inc = pass_r + 15'h0001;
    pass_nxt = pass_r;
    if (clr) begin
      pass_nxt = '0;
    end else if (inc && pass_r != 15'h7fff) begin
      pass_nxt = pass_inc;
    end
    done = inc && counted && (pass_inc >= limit);
  end

  // Counter register, frozen while the clock enable is low.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pass_r <= '0;
    end else if (ce) begin
      pass_r <= pass_nxt;
    end
  end

  assign passes = pass_r;

endmodule

// [verilog/scm_top.sv]
// Scan start, abort, repeat count and monitor control behind Wishbone.
`timescale 1ns/1ps
`include "scm_params.svh"
// Operation
// - Abort stops host scan on bus/hold source.
// - Abort resets trigger system to idle when idle or when it stops the scan.
// - Abort keeps all scan configuration.
// - Interface clear stops host-started scan.
// - Panel scan stopped by reset or keys.
// - One start runs list repeat-count times.
// - Downloaded lists ignore repeat count.
// - Min keyword stores 1, max 32767.
// - Repeat count defaults and resets to 1.
// - Count query returns stored, min, max.
// - Monitor card is 1..99 or auto.
// - Auto tracks last switched module.
// - Instrument reset selects auto card.
// - Monitor enable shows or hides display.
// - Monitor works only in switchbox mode.
// - Stop when passes equal repeat count.
module scm_top (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Asynchronous pins: interface clear and front-panel controls.
  input wire logic ifc_clear,
  input wire logic panel_reset_key,
  input wire logic panel_clear_key,
  input wire logic panel_start,
  // Scan sequencer and switching logic on this clock.
  input wire logic pass_end,
  input wire logic switch_cmd,
  input wire logic [6:0] switch_card,
  // Scan and monitor outputs.
  output logic scan_running,
  output logic trig_reset,
  output logic trig_idle,
  output logic loop_forever_enable,
  output logic monitor_on,
  output logic [6:0] monitor_card
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Merge a write into a register honouring the byte lanes.
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] din,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = din[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Range check shared by card and count writes.
  function automatic logic in_range(input logic [15:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  logic [3:0] pin_rise; // Clear, panel reset, panel clear, panel start.

  scm_sync #(.W(4)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .pin({panel_start, panel_clear_key, panel_reset_key, ifc_clear}),
    .rise(pin_rise)
  );

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic ack_r;       // Answer flag, high for one cycle per request.
  logic ack_nxt;
  logic [31:0] rdat_r; // Registered read data.
  logic [31:0] rdat_nxt;
  logic req;         // A new request not yet answered.
  logic wr;          // A write taken at this edge, answered the next cycle.
  logic [31:0] wmix; // Write data merged through the byte lanes.

  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = req && wb_we_i;

  // Command pulses come from the low byte lane of the command word.
  logic cmd_start;
  logic cmd_abort;
  logic cmd_rst;
  assign cmd_start = wr && wb_adr_i == `SCM_OFF_CMD && wb_sel_i[0] &&
                     wb_dat_i[`SCM_CMD_START];
  assign cmd_abort = wr && wb_adr_i == `SCM_OFF_CMD && wb_sel_i[0] &&
                     wb_dat_i[`SCM_CMD_ABORT];
  assign cmd_rst = wr && wb_adr_i == `SCM_OFF_CMD && wb_sel_i[0] &&
                   wb_dat_i[`SCM_CMD_RST];

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  scm_pkg::scm_cfg_t cfg_r; // Loop, source, list kind, mode, monitor.
  scm_pkg::scm_cfg_t cfg_nxt;
  logic [14:0] count_r;      // Stored repeat count.
  logic [14:0] count_nxt;
  logic [6:0] card_r;        // Explicit monitored card.
  logic [6:0] card_nxt;
  logic auto_r;              // Automatic card selection.
  logic auto_nxt;
  logic [6:0] last_r;        // Last card addressed by switching.
  logic [6:0] last_nxt;
  logic err_r;               // Sticky rejected-write flag.
  logic err_nxt;
  scm_pkg::scm_kw_t kw;

  // Configuration writes; abort touches none of this state.
  always_comb begin
    cfg_nxt = cfg_r;
    count_nxt = count_r;
    card_nxt = card_r;
    auto_nxt = auto_r;
    last_nxt = last_r;
    err_nxt = err_r;
    wmix = lane_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
    kw = scm_pkg::scm_kw_t'(wmix[`SCM_CNT_KW_LSB +: 2]);
    // The switching logic names a card; auto mode follows it.
    if (switch_cmd) begin
      last_nxt = switch_card;
    end
    if (wr && wb_adr_i == `SCM_OFF_CFG && wb_sel_i[0]) begin
      cfg_nxt = scm_pkg::scm_cfg_t'(wmix[6:0]);
    end
    if (wr && wb_adr_i == `SCM_OFF_COUNT) begin
      case (kw)
        scm_pkg::SCM_KW_MIN: count_nxt = `SCM_COUNT_MIN;
        scm_pkg::SCM_KW_MAX: count_nxt = `SCM_COUNT_MAX;
        scm_pkg::SCM_KW_NUM: begin
          // Out-of-range numbers keep the old count and flag it.
          if (in_range(wmix[15:0], 16'h0001, 16'h7fff)) begin
            count_nxt = wmix[14:0];
          end else begin
            err_nxt = 1'b1;
          end
        end
        default: err_nxt = 1'b1;
      endcase
    end
    if (wr && wb_adr_i == `SCM_OFF_MONCARD && wb_sel_i[0]) begin
      if (wmix[`SCM_MON_AUTO]) begin
        auto_nxt = 1'b1;
      end else if (in_range({9'h000, wmix[6:0]}, 16'h0001, 16'h0063))
      begin
        auto_nxt = 1'b0;
        card_nxt = wmix[6:0];
      end else begin
        err_nxt = 1'b1;
      end
    end
    // Writing one to the error bit clears it; a new error wins.
    if (wr && wb_adr_i == `SCM_OFF_STATUS && wb_sel_i[0] &&
        wb_dat_i[`SCM_ST_ERR] && err_nxt == err_r) begin
      err_nxt = 1'b0;
    end
    // Instrument reset returns count, configuration and auto selection to their reset values.
    if (cmd_rst) begin
      count_nxt = `SCM_COUNT_RST;
      auto_nxt = 1'b1;
      cfg_nxt = scm_pkg::scm_cfg_t'(`SCM_CFG_RST);
    end
  end

  // Register the configuration group.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r <= scm_pkg::scm_cfg_t'(`SCM_CFG_RST);
      count_r <= `SCM_COUNT_RST;
      card_r <= `SCM_CARD_RST;
      auto_r <= 1'b1;
      last_r <= `SCM_CARD_RST;
      err_r <= 1'b0;
    end else if (ce) begin
      cfg_r <= cfg_nxt;
      count_r <= count_nxt;
      card_r <= card_nxt;
      auto_r <= auto_nxt;
      last_r <= last_nxt;
      err_r <= err_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Scan sequencing and trigger reset
  // ----------------------------------------------------------------------
  scm_pkg::scm_state_t state_r; // Scan state.
  scm_pkg::scm_state_t state_nxt;
  logic panel_r;     // The running scan came from the front panel.
  logic panel_nxt;
  logic trig_rst_r;  // One-cycle trigger system reset.
  logic trig_rst_nxt;
  logic run_r;       // Registered running flag, drives the output pin.
  logic run_nxt;
  logic idle_r;      // Registered idle flag, drives the output pin.
  logic idle_nxt;
  logic pass_clr;
  logic pass_done;
  logic stop_req;
  logic counted;
  logic [14:0] limit;
  logic [14:0] passes;

  // Downloaded lists run once per start unless looping.
  assign counted = !cfg_r.loop_forever_enable;
  assign limit = cfg_r.dl_list ? 15'h0001 : count_r;

  scm_pass_ctr u_pass (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .clr(pass_clr),
    .inc(state_r == scm_pkg::SCM_RUN && pass_end),
    .counted(counted),
    .limit(limit),
    .done(pass_done),
    .passes(passes)
  );

  // Gather the stop sources; only abort and interface clear are tied to a host-started scan.
  always_comb begin
    stop_req = 1'b0;
    if (!panel_r && cmd_abort && (cfg_r.src == scm_pkg::SCM_SRC_BUS ||
        cfg_r.src == scm_pkg::SCM_SRC_HOLD)) begin
      stop_req = 1'b1;
    end
    if (!panel_r && pin_rise[0]) begin
      stop_req = 1'b1;
    end
    if (cmd_rst || pin_rise[1] || pin_rise[2]) begin
      stop_req = 1'b1;
    end
  end

  // Scan state machine; a stop always passes through the reset state.
  always_comb begin
    state_nxt = state_r;
    panel_nxt = panel_r;
    trig_rst_nxt = 1'b0;
    pass_clr = 1'b0;
    case (state_r)
      scm_pkg::SCM_IDLE: begin
        // An abort here is harmless; triggers are pulsed back to idle.
        if (cmd_abort || cmd_rst) begin
          trig_rst_nxt = 1'b1;
        end else if (cmd_start || pin_rise[3]) begin
          state_nxt = scm_pkg::SCM_RUN;
          panel_nxt = !cmd_start;
          pass_clr = 1'b1;
        end
      end
      scm_pkg::SCM_RUN: begin
        if (stop_req || pass_done) begin
          state_nxt = scm_pkg::SCM_STOP;
        end
      end
      scm_pkg::SCM_STOP: begin
        state_nxt = scm_pkg::SCM_IDLE;
        trig_rst_nxt = 1'b1;
      end
      default: begin
        state_nxt = scm_pkg::SCM_IDLE;
      end
    endcase
    // Flags follow the next state so the pins leave straight from flops.
    run_nxt = state_nxt != scm_pkg::SCM_IDLE;
    idle_nxt = state_nxt == scm_pkg::SCM_IDLE;
  end

  // Register the sequencing group.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= scm_pkg::SCM_IDLE;
      panel_r <= 1'b0;
      trig_rst_r <= 1'b0;
      run_r <= 1'b0;
      idle_r <= 1'b1;
    end else if (ce) begin
      state_r <= state_nxt;
      panel_r <= panel_nxt;
      trig_rst_r <= trig_rst_nxt;
      run_r <= run_nxt;
      idle_r <= idle_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Read data, answer and registered outputs
  // ----------------------------------------------------------------------
  logic mon_on_r;
  logic [6:0] mon_card_r;

  // Read mux; unmapped offsets read zero and still get an answer.
  always_comb begin
    ack_nxt = req;
    rdat_nxt = rdat_r;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        `SCM_OFF_CFG: rdat_nxt = {25'h0000000, cfg_r};
        `SCM_OFF_COUNT: rdat_nxt = {17'h00000, count_r};
        `SCM_OFF_CNT_MIN: rdat_nxt = {17'h00000, `SCM_COUNT_MIN};
        `SCM_OFF_CNT_MAX: rdat_nxt = {17'h00000, `SCM_COUNT_MAX};
        `SCM_OFF_MONCARD: rdat_nxt = {17'h00000,
                                      auto_r ? last_r : card_r,
                                      auto_r, card_r};
        `SCM_OFF_STATUS: rdat_nxt = {1'b0, passes, 13'h0000, err_r,
                                     panel_r,
                                     state_r != scm_pkg::SCM_IDLE};
        default: rdat_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Bus answer and outputs, all from flip-flops.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
      mon_on_r <= 1'b0;
      mon_card_r <= `SCM_CARD_RST;
    end else if (ce) begin
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
      // The display is driven only in the switchbox configuration.
      mon_on_r <= cfg_nxt.mon_en && cfg_nxt.switchbox;
      mon_card_r <= auto_nxt ? last_nxt : card_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign scan_running = run_r;
  assign trig_reset = trig_rst_r;
  assign trig_idle = idle_r;
  assign loop_forever_enable = cfg_r.loop_forever_enable;
  assign monitor_on = mon_on_r;
  assign monitor_card = mon_card_r;

endmodule

// [bench/scm_host.sv]
// Wishbone classic host model that issues one register access per request.
`timescale 1ns/1ps
module scm_host (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Request from the bench; done pulses once the answer is taken.
  input wire logic go,
  input wire logic we,
  input wire logic [7:0] adr,
  input wire logic [31:0] dat,
  output logic done,
  output logic [31:0] rdat,
  // Bus master side; stb is the same wire as cyc.
  output logic cyc,
  output logic wwe,
  output logic [7:0] wadr,
  output logic [31:0] wdat,
  input wire logic ack,
  input wire logic [31:0] din
);
  // Holds the request until ack is sampled high, then inverts the released
  // address and data, so a slave that reads a stale bus gets no help.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc <= 1'b0;
      done <= 1'b0;
      rdat <= 32'h0;
      wwe <= 1'b0;
      wadr <= 8'h00;
      wdat <= 32'h0;
    end else if (cyc && ack) begin
      cyc <= 1'b0;
      done <= 1'b1;
      rdat <= din;
      wadr <= ~wadr;
      wdat <= ~wdat;
    end else if (go && !cyc && !done) begin
      cyc <= 1'b1;
      wwe <= we;
      wadr <= adr;
      wdat <= dat;
    end else begin
      done <= 1'b0;
    end
  end
endmodule

// [bench/scm_top_props.sv]
// Concurrent checks on the scan controller ports.
`timescale 1ns/1ps
`include "scm_params.svh"
module scm_top_props (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Bus request and answer.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Scan and monitor state.
  input wire logic scan_running,
  input wire logic trig_reset,
  input wire logic trig_idle,
  input wire logic loop_forever_enable,
  input wire logic monitor_on,
  input wire logic [6:0] monitor_card
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // A request taken at this edge, and a command word among them.
  logic req;
  logic cmd;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  assign cmd = req && wb_we_i && wb_sel_i[0] && wb_adr_i == `SCM_OFF_CMD;

  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_answer: assert property (req |=> wb_ack_o)
    else $error("request not answered next cycle");
  chk_idle_state: assert property (trig_idle != scan_running)
    else $error("idle and running disagree");
  chk_treset_idle: assert property (
    trig_reset |-> trig_idle ##1 !trig_reset)
    else $error("trigger reset pulse bad");
  chk_fall_reset: assert property (
    $fell(scan_running) |-> trig_reset)
    else $error("scan ended without trigger reset");
  chk_start_run: assert property (
    cmd && wb_dat_i[2:0] == 3'h1 && trig_idle |=> scan_running)
    else $error("start did not run the scan");
  chk_idle_abort: assert property (
    cmd && wb_dat_i[2:0] == 3'h2 && trig_idle |=> trig_reset && trig_idle)
    else $error("idle abort mishandled");
  chk_abort_keep: assert property (
    cmd && wb_dat_i[2:0] == 3'h2 |=>
      $stable(loop_forever_enable) && $stable(monitor_on))
    else $error("abort changed the setup");
  chk_rst_clear: assert property (
    cmd && wb_dat_i[`SCM_CMD_RST] |=>
      !loop_forever_enable && !monitor_on ##1 !scan_running)
    else $error("instrument reset did not clear");
  chk_card_range: assert property (
    monitor_card >= `SCM_CARD_MIN && monitor_card <= `SCM_CARD_MAX)
    else $error("monitored card out of range");
  cover property ($rose(scan_running));
  cover property ($fell(scan_running));
  cover property (cmd && wb_dat_i[`SCM_CMD_ABORT]);
endmodule
bind scm_top scm_top_props i_scm_top_props (.clk, .rst_b, .ce, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
  .scan_running, .trig_reset, .trig_idle, .loop_forever_enable,
  .monitor_on, .monitor_card);

// [bench/scm_top_tb.sv]
// Self-checking bench for the scan controller with a host bus model.
`timescale 1ns/1ps
`include "scm_params.svh"
module scm_top_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic go = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  // Clear, reset key, clear key and panel start, in that bit order.
  logic [3:0] pins = 4'h0;
  logic pass_end = 1'b0;
  logic ce = 1'b1;
  logic [3:0] sel = 4'hf;
  logic switch_cmd = 1'b0;
  logic [6:0] switch_card = 7'h01;
  logic done, cyc, wwe, ack, running, idle, loop, mon_on;
  logic [7:0] wadr;
  logic [31:0] rdat, wdat, din, r;
  logic [6:0] card;
  logic [17:0] corner [6] = '{18'h0, 18'h08000, 18'h30005, 18'h10000,
    18'h20000, 18'h07fff};
  int miscompares = 0;
  int checks_done = 0;
  integer seed = 32'h1b72;
  always #2 clk = ~clk;

  scm_host i_scm_host (.clk(clk), .rst_b(rst_b), .go(go), .we(we),
    .adr(adr), .dat(dat), .done(done), .rdat(rdat), .cyc(cyc), .wwe(wwe),
    .wadr(wadr), .wdat(wdat), .ack(ack), .din(din));
  scm_top i_scm_top (.clk(clk), .rst_b(rst_b), .ce(ce), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(wwe), .wb_adr_i(wadr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(din), .wb_ack_o(ack), .ifc_clear(pins[0]),
    .panel_reset_key(pins[1]), .panel_clear_key(pins[2]),
    .panel_start(pins[3]), .pass_end(pass_end), .switch_cmd(switch_cmd),
    .switch_card(switch_card), .scan_running(running), .trig_reset(),
    .trig_idle(idle), .loop_forever_enable(loop), .monitor_on(mon_on),
    .monitor_card(card));

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One access; the wait is bounded so a silent slave ends the run.
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    @(posedge clk);
    go <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (done === 1'b1) break;
    end
    go <= 1'b0;
    if (n == 20) begin
      miscompares++;
      $display("MISMATCH at %0t: bus access not answered", $time);
      close_out();
    end
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
    r = rdat;
  endtask
  // Pin held long enough for the two-flop synchroniser to see it.
  task automatic pulse_pin(input int k);
    @(posedge clk);
    pins[k] <= 1'b1;
    repeat (4) @(posedge clk);
    pins[k] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic pass(input int k);
    repeat (k) begin
      @(posedge clk);
      pass_end <= 1'b1;
      @(posedge clk);
      pass_end <= 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic scan(input logic [31:0] c);
    bus(1'b1, `SCM_OFF_CFG, c);
    bus(1'b1, `SCM_OFF_CMD, 32'h1);
  endtask
  function automatic logic [31:0] cfgw(logic l, scm_pkg::scm_src_t s,
      logic d, logic b, logic m);
    scm_pkg::scm_cfg_t c;
    c = '{m, b, d, s, l};
    return {25'h0, c};
  endfunction
  // Stored count after a write: keywords win, bad numbers keep the old one.
  function automatic logic [14:0] cnt_exp(logic [14:0] old, logic [1:0] kw,
      logic [15:0] n);
    if (kw == 2'h1) return `SCM_COUNT_MIN;
    if (kw == 2'h2) return `SCM_COUNT_MAX;
    if (kw == 2'h0 && n >= 16'h1 && n <= 16'h7fff) return n[14:0];
    return old;
  endfunction

  initial begin
    int i;
    logic [31:0] v;
    logic [14:0] cnt;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({idle, running, loop, mon_on, card}, 11'h401);
    rd(`SCM_OFF_COUNT);
    chk(r[14:0], 15'h0001);
    rd(`SCM_OFF_CNT_MIN);
    chk(r, 32'h1);
    rd(`SCM_OFF_CNT_MAX);
    chk(r, 32'h7fff);
    cnt = 15'h0001;
    for (i = 0; i < 20; i++) begin
      v = $random(seed);
      v[31:16] = 16'(i % 3);
      if (i < 6) v = {14'h0, corner[i]};
      bus(1'b1, `SCM_OFF_COUNT, v);
      cnt = cnt_exp(cnt, v[17:16], v[15:0]);
      rd(`SCM_OFF_COUNT);
      chk(r[14:0], cnt);
    end
    rd(`SCM_OFF_STATUS);
    chk(r[2], 1'b1);
    bus(1'b1, `SCM_OFF_STATUS, 32'h4);
    rd(`SCM_OFF_STATUS);
    chk(r[2], 1'b0);
    $display("test count done");
    bus(1'b1, `SCM_OFF_COUNT, 32'h3);
    scan(cfgw(0, scm_pkg::SCM_SRC_BUS, 0, 0, 0));
    pass(2);
    chk(running, 1'b1);
    // A pass end while the clock enable is low must not be counted.
    ce <= 1'b0;
    pass(1);
    ce <= 1'b1;
    chk(running, 1'b1);
    pass(1);
    chk(running, 1'b0);
    scan(cfgw(0, scm_pkg::SCM_SRC_BUS, 1, 0, 0));
    pass(1);
    chk(running, 1'b0);
    $display("test counted done");
    for (i = 0; i < 5; i++) begin
      v = cfgw(1, scm_pkg::scm_src_t'(i), 0, 0, 0);
      scan(v);
      pass(4);
      bus(1'b1, `SCM_OFF_CMD, 32'h2);
      repeat (2) @(posedge clk);
      chk(running, !(i == 0 || i == 3));
      pulse_pin(0);
      chk(running, 1'b0);
      rd(`SCM_OFF_CFG);
      chk(r, v);
      rd(`SCM_OFF_COUNT);
      chk(r[14:0], 15'h0003);
    end
    $display("test abort done");
    bus(1'b1, `SCM_OFF_CFG, cfgw(1, scm_pkg::SCM_SRC_BUS, 0, 0, 0));
    for (i = 1; i < 4; i++) begin
      pulse_pin(3);
      chk(running, 1'b1);
      bus(1'b1, `SCM_OFF_CMD, 32'h2);
      pulse_pin(0);
      chk(running, 1'b1);
      if (i < 3) pulse_pin(i);
      else bus(1'b1, `SCM_OFF_CMD, 32'h4);
      repeat (2) @(posedge clk);
      chk(running, 1'b0);
    end
    rd(`SCM_OFF_COUNT);
    chk(r[14:0], 15'h0001);
    bus(1'b1, `SCM_OFF_CMD, 32'h2);
    chk(idle, 1'b1);
    $display("test panel done");
    for (i = 0; i < 4; i++) begin
      bus(1'b1, `SCM_OFF_CFG, cfgw(0, scm_pkg::SCM_SRC_BUS, 0, i[0], i[1]));
      chk(mon_on, i == 3);
    end
    // Without the low byte lane the configuration write is ignored.
    sel <= 4'he;
    bus(1'b1, `SCM_OFF_CFG, 32'h0);
    sel <= 4'hf;
    chk(mon_on, 1'b1);
    bus(1'b1, `SCM_OFF_MONCARD, 32'h2);
    bus(1'b1, `SCM_OFF_MONCARD, 32'h64);
    chk(card, 7'h02);
    bus(1'b1, `SCM_OFF_CMD, 32'h4);
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      v = v[6:0] % 99 + 1;
      @(posedge clk);
      switch_card <= v[6:0];
      switch_cmd <= 1'b1;
      @(posedge clk);
      switch_cmd <= 1'b0;
      repeat (2) @(posedge clk);
      chk(card, v[6:0]);
    end
    bus(1'b1, `SCM_OFF_MONCARD, 32'h5);
    chk(card, 7'h05);
    bus(1'b1, `SCM_OFF_MONCARD, 32'h80);
    chk(card, v[6:0]);
    $display("test monitor done");
    close_out();
  end
endmodule
